/* File: include/i2crp_pkg.sv */
/*
 * Shared constants and types for the two-wire slave register port.
 * Assumes a 25 MHz system clock and that the register file lives outside this block.
 */
package i2crp_pkg;

   // System clock rate in hertz.
   localparam int unsigned CLK_HZ          = 25_000_000;
   // Bus idle time after which a transaction in progress is abandoned.
   localparam int unsigned TIMEOUT_MS      = 25;
   localparam int unsigned TIMEOUT_CYCLES  = CLK_HZ / 1000 * TIMEOUT_MS;
   localparam int unsigned TIMEOUT_W       = $clog2(TIMEOUT_CYCLES + 1);

   // Upper six bits of the slave address; the address select pin supplies bit 0.
   localparam logic [5:0]  SLAVE_ADDR_HI   = 6'h24;

   // Pointer byte layout and reset value.
   localparam int unsigned PTR_INC_BIT     = 7;
   localparam int unsigned PTR_REG_W       = 5;
   localparam logic [7:0]  PTR_RESET       = 8'h00;

   // Bits per byte and index of the last bit within a byte.
   localparam int unsigned BYTE_BITS       = 8;
   localparam logic [2:0]  LAST_BIT        = 3'h7;

   // Positions of the pins within the input synchroniser vector.
   localparam int unsigned SYNC_W          = 3;
   localparam int unsigned SCL_IDX         = 0;
   localparam int unsigned SDA_IDX         = 1;
   localparam int unsigned ASEL_IDX        = 2;

   typedef enum {
      ST_IDLE,
      ST_RX,
      ST_ACK,
      ST_TX,
      ST_TX_ACK,
      ST_IGNORE
   } i2crp_state_t;

   typedef struct packed {
      logic                 strobe;
      logic [PTR_REG_W-1:0] addr;
      logic [BYTE_BITS-1:0] data;
   } i2crp_wr_t;

endpackage : i2crp_pkg

/* File: rtl/i2crp_slave.sv */
/*
 * Two-wire bus slave that gives an external master byte access to an internal register file
 * through a register pointer with an auto-increment flag.
 * Assumes the register file outside answers i_reg_rdata combinationally for o_reg_addr, and
 * that the pad logic pulls SDA low while o_sda_oe_n is low and releases it otherwise.
 */
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Slave only; clock line is an input and is never driven.
// - Data line is only pulled low or released, never driven high.
// - Eight-bit groups; data changes while clock low, sampled at clock rise.
// - Abandon any transaction when the bus stays idle longer than 25 ms.
// - Data falling with clock high is start; rising with clock high is stop.
// - Start during an active transaction is a repeated start with a new address phase.
// - After start, first byte upper seven bits are address, eighth is direction.
// - Address is 1001000 or 1001001 from the select pin, sampled continuously.
// - Acknowledge matching address and every written byte by pulling data low.
// - Released line during acknowledge is not-acknowledge; no match leaves line released.
// - Accept clock rates up to 100 kHz standard and 400 kHz fast.
// - First written byte loads the pointer; later bytes store at the pointed register.
// - Low five pointer bits select the register for writes and reads.
// - Pointer top bit set advances pointer after each write; clear keeps it.
// - With the flag set the pointer also advances after each byte sent.
// - Pointer is kept between transactions so a plain read repeats the last register.
// - Read drives the pointed register most significant bit first on master clocks.
// - Stop sending and release data on not-acknowledge, start or stop.
module i2crp_slave #(
   parameter int unsigned P_TIMEOUT_CYCLES = i2crp_pkg::TIMEOUT_CYCLES
) (
   input  wire logic                                 i_clock,
   input  wire logic                                 i_rst_n,
   input  wire logic                                 i_scl,
   input  wire logic                                 i_sda,
   input  wire logic                                 i_address_select_pin,
   input  wire logic [i2crp_pkg::BYTE_BITS-1:0]      i_reg_rdata,
   output logic                                      o_sda_o,
   output logic                                      o_sda_oe_n,
   output logic [i2crp_pkg::PTR_REG_W-1:0]           o_reg_addr,
   output var i2crp_pkg::i2crp_wr_t                  o_reg_wr,
   output logic                                      o_reg_rd_pulse,
   output logic                                      o_busy
);

   localparam int unsigned CNT_W = i2crp_pkg::TIMEOUT_W;

   logic [1:0]                            rst_sync_ff;
   logic                                  rst_n;
   logic [i2crp_pkg::SYNC_W-1:0]          pin_meta_ff;
   logic [i2crp_pkg::SYNC_W-1:0]          pin_sync_ff;
   logic                                  scl_prev_ff;
   logic                                  sda_prev_ff;
   logic                                  scl;
   logic                                  sda;
   logic                                  scl_rise;
   logic                                  scl_fall;
   logic                                  start_det;
   logic                                  stop_det;
   logic                                  line_change;
   logic [6:0]                            own_addr;
   logic [CNT_W-1:0]                      idle_cnt_ff;
   logic                                  timeout_hit;
   i2crp_pkg::i2crp_state_t               state_ff;
   logic [2:0]                            bit_cnt_ff;
   logic                                  byte_done_ff;
   logic [i2crp_pkg::BYTE_BITS-1:0]       shift_ff;
   logic [i2crp_pkg::BYTE_BITS-1:0]       tx_ff;
   logic                                  is_addr_ff;
   logic                                  expect_ptr_ff;
   logic                                  go_tx_ff;
   logic                                  acked_ff;
   logic                                  sda_low_ff;
   logic [i2crp_pkg::BYTE_BITS-1:0]       ptr_ff;
   logic [i2crp_pkg::PTR_REG_W-1:0]       nxt_ptr_addr;
   logic                                  bus_abort;
   logic                                  rx_byte_end;
   logic                                  tx_byte_end;
   logic                                  ptr_load;
   logic                                  data_store;
   logic                                  ptr_inc;

   // Reset is applied at once and released through two flops.
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_sync_ff <= 2'h0;
      end else begin
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
      end
   end

   assign rst_n = rst_sync_ff[1];

   // Pins are asynchronous to i_clock; the first stage is read only by the second.
   always_ff @(posedge i_clock or negedge rst_n) begin
      if (!rst_n) begin
         pin_meta_ff <= 3'h3;
         pin_sync_ff <= 3'h3;
         scl_prev_ff <= 1'b1;
         sda_prev_ff <= 1'b1;
      end else begin
         pin_meta_ff <= {i_address_select_pin, i_sda, i_scl};
         pin_sync_ff <= pin_meta_ff;
         scl_prev_ff <= pin_sync_ff[i2crp_pkg::SCL_IDX];
         sda_prev_ff <= pin_sync_ff[i2crp_pkg::SDA_IDX];
      end
   end

   assign scl = pin_sync_ff[i2crp_pkg::SCL_IDX];
   assign sda = pin_sync_ff[i2crp_pkg::SDA_IDX];

   // At 25 MHz a 400 kHz clock gives at least 30 samples per phase, so edges are never missed.
   assign scl_rise    = scl & ~scl_prev_ff;
   assign scl_fall    = ~scl & scl_prev_ff;
   assign start_det   = scl & scl_prev_ff & sda_prev_ff & ~sda;
   assign stop_det    = scl & scl_prev_ff & ~sda_prev_ff & sda;
   assign line_change = (scl ^ scl_prev_ff) | (sda ^ sda_prev_ff);

   // The select pin is re-read on every clock, so a strap change takes effect two clocks later, once through the synchroniser.
   assign own_addr = {i2crp_pkg::SLAVE_ADDR_HI, pin_sync_ff[i2crp_pkg::ASEL_IDX]};

   // Any line activity restarts the idle count; only an open transaction is timed.
   always_ff @(posedge i_clock or negedge rst_n) begin
      if (!rst_n) begin
         idle_cnt_ff <= '0;
      end else if (state_ff == i2crp_pkg::ST_IDLE || line_change || timeout_hit) begin
         idle_cnt_ff <= '0;
      end else begin
         idle_cnt_ff <= idle_cnt_ff + CNT_W'(1);
      end
   end

   assign timeout_hit = (idle_cnt_ff == CNT_W'(P_TIMEOUT_CYCLES - 1));

   assign bus_abort   = start_det | stop_det | timeout_hit;
   assign rx_byte_end = (state_ff == i2crp_pkg::ST_RX) & scl_fall & byte_done_ff & ~bus_abort;
   assign tx_byte_end = (state_ff == i2crp_pkg::ST_TX) & scl_fall & byte_done_ff & ~bus_abort;
   assign ptr_load    = rx_byte_end & ~is_addr_ff & expect_ptr_ff;
   assign data_store  = rx_byte_end & ~is_addr_ff & ~expect_ptr_ff;
   assign ptr_inc     = ptr_ff[i2crp_pkg::PTR_INC_BIT];
   assign nxt_ptr_addr = ptr_ff[i2crp_pkg::PTR_REG_W-1:0] + 5'h01;

   // The pointer survives stop and repeated start; only reset clears it.
   always_ff @(posedge i_clock or negedge rst_n) begin
      if (!rst_n) begin
         ptr_ff <= i2crp_pkg::PTR_RESET;
      end else if (ptr_load) begin
         ptr_ff <= shift_ff;
      end else if ((data_store || tx_byte_end) && ptr_inc) begin
         // Only the register field advances; the flag bit is left as written.
         ptr_ff[i2crp_pkg::PTR_REG_W-1:0] <= nxt_ptr_addr;
      end
   end

   assign o_reg_addr = ptr_ff[i2crp_pkg::PTR_REG_W-1:0];

   // Protocol sequencing, shifting and data line control.
   always_ff @(posedge i_clock or negedge rst_n) begin
      if (!rst_n) begin
         state_ff       <= i2crp_pkg::ST_IDLE;
         bit_cnt_ff     <= 3'h0;
         byte_done_ff   <= 1'b0;
         shift_ff       <= 8'h00;
         tx_ff          <= 8'h00;
         is_addr_ff     <= 1'b0;
         expect_ptr_ff  <= 1'b0;
         go_tx_ff       <= 1'b0;
         acked_ff       <= 1'b0;
         sda_low_ff     <= 1'b0;
         o_reg_wr       <= '0;
         o_reg_rd_pulse <= 1'b0;
      end else begin
         o_reg_wr.strobe <= 1'b0;
         o_reg_rd_pulse  <= 1'b0;
         if (stop_det || timeout_hit) begin
            // Stop or a long idle ends everything and frees the data line.
            state_ff     <= i2crp_pkg::ST_IDLE;
            byte_done_ff <= 1'b0;
            sda_low_ff   <= 1'b0;
         end else if (start_det) begin
            // A start in any state, even mid byte, opens a fresh address phase.
            state_ff     <= i2crp_pkg::ST_RX;
            bit_cnt_ff   <= 3'h0;
            byte_done_ff <= 1'b0;
            is_addr_ff   <= 1'b1;
            sda_low_ff   <= 1'b0;
         end else begin
            case (state_ff)
               i2crp_pkg::ST_IDLE: begin
                  sda_low_ff <= 1'b0;
               end
               i2crp_pkg::ST_RX: begin
                  if (scl_rise) begin
                     shift_ff     <= {shift_ff[6:0], sda};
                     bit_cnt_ff   <= bit_cnt_ff + 3'h1;
                     byte_done_ff <= (bit_cnt_ff == i2crp_pkg::LAST_BIT);
                  end else if (rx_byte_end) begin
                     byte_done_ff <= 1'b0;
                     if (is_addr_ff) begin
                        is_addr_ff <= 1'b0;
                        if (shift_ff[7:1] == own_addr) begin
                           go_tx_ff      <= shift_ff[0];
                           expect_ptr_ff <= ~shift_ff[0];
                           sda_low_ff    <= 1'b1;
                           state_ff      <= i2crp_pkg::ST_ACK;
                        end else begin
                           // Another slave's address: stay off the line until the next start.
                           sda_low_ff <= 1'b0;
                           state_ff   <= i2crp_pkg::ST_IGNORE;
                        end
                     end else begin
                        if (!expect_ptr_ff) begin
                           o_reg_wr.strobe <= 1'b1;
                           o_reg_wr.addr   <= ptr_ff[i2crp_pkg::PTR_REG_W-1:0];
                           o_reg_wr.data   <= shift_ff;
                        end
                        expect_ptr_ff <= 1'b0;
                        go_tx_ff      <= 1'b0;
                        sda_low_ff    <= 1'b1;
                        state_ff      <= i2crp_pkg::ST_ACK;
                     end
                  end
               end
               i2crp_pkg::ST_ACK: begin
                  if (scl_fall) begin
                     bit_cnt_ff <= 3'h0;
                     if (go_tx_ff) begin
                        // First read byte goes out MSB first right after the address acknowledge.
                        tx_ff          <= i_reg_rdata;
                        sda_low_ff     <= ~i_reg_rdata[7];
                        o_reg_rd_pulse <= 1'b1;
                        state_ff       <= i2crp_pkg::ST_TX;
                     end else begin
                        sda_low_ff <= 1'b0;
                        state_ff   <= i2crp_pkg::ST_RX;
                     end
                  end
               end
               i2crp_pkg::ST_TX: begin
                  if (scl_rise) begin
                     bit_cnt_ff   <= bit_cnt_ff + 3'h1;
                     byte_done_ff <= (bit_cnt_ff == i2crp_pkg::LAST_BIT);
                  end else if (tx_byte_end) begin
                     // Release for the master's acknowledge bit.
                     byte_done_ff <= 1'b0;
                     sda_low_ff   <= 1'b0;
                     state_ff     <= i2crp_pkg::ST_TX_ACK;
                  end else if (scl_fall) begin
                     // The next bit changes only while the clock is low.
                     tx_ff      <= {tx_ff[6:0], 1'b0};
                     sda_low_ff <= ~tx_ff[6];
                  end
               end
               i2crp_pkg::ST_TX_ACK: begin
                  if (scl_rise) begin
                     acked_ff <= ~sda;
                  end else if (scl_fall) begin
                     bit_cnt_ff <= 3'h0;
                     if (acked_ff) begin
                        // The pointer has already moved on if the flag is set.
                        tx_ff          <= i_reg_rdata;
                        sda_low_ff     <= ~i_reg_rdata[7];
                        o_reg_rd_pulse <= 1'b1;
                        state_ff       <= i2crp_pkg::ST_TX;
                     end else begin
                        // A not-acknowledge ends the read; the line stays released.
                        sda_low_ff <= 1'b0;
                        state_ff   <= i2crp_pkg::ST_IGNORE;
                     end
                  end
               end
               i2crp_pkg::ST_IGNORE: begin
                  sda_low_ff <= 1'b0;
               end
               default: begin
                  sda_low_ff <= 1'b0;
                  state_ff   <= i2crp_pkg::ST_IDLE;
               end
            endcase
         end
      end
   end

   // The pad can only pull low; a one is sent by releasing the line.
   assign o_sda_o    = 1'b0;
   assign o_sda_oe_n = ~sda_low_ff;
   // There is deliberately no clock output: this end never stretches or drives it.
   assign o_busy     = (state_ff != i2crp_pkg::ST_IDLE);

endmodule : i2crp_slave

`default_nettype wire

/* File: verification/i2crp_chk.sv */
/* Concurrent checks on the pins of the two-wire slave port.
   Assumes it is bound to i2crp_slave and sees only that module's ports. */
`timescale 1ns/1ps
`default_nettype none
module i2crp_chk #(
   parameter int unsigned P_TIMEOUT_CYCLES = 2000
) (
   input wire logic                 i_clock,
   input wire logic                 i_rst_n,
   input wire logic                 i_scl,
   input wire logic                 i_sda,
   input wire logic                 i_address_select_pin,
   input wire logic [7:0]           i_reg_rdata,
   input wire logic                 o_sda_o,
   input wire logic                 o_sda_oe_n,
   input wire logic [4:0]           o_reg_addr,
   input wire i2crp_pkg::i2crp_wr_t o_reg_wr,
   input wire logic                 o_reg_rd_pulse,
   input wire logic                 o_busy
);
   logic [31:0] idle_ff;
   logic [1:0]  pins_ff;
   // A saturating stall counter stands in for a repetition far beyond what the tools unroll.
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pins_ff <= 2'h3;
         idle_ff <= 32'h0;
      end else begin
         pins_ff <= {i_scl, i_sda};
         idle_ff <= ({i_scl, i_sda} != pins_ff) ? 32'h0 : idle_ff + {31'h0, ~&idle_ff};
      end
   end
   default clocking @(posedge i_clock);
   endclocking
   default disable iff (!i_rst_n);
   a_sda_value_low: assert property (o_sda_o == 1'b0)
      else $error("data pin drive value is not low");
   a_start_busy: assert property ($fell(i_sda) && i_scl && $past(i_scl) |-> ##[1:5] o_busy)
      else $error("start did not open a transaction");
   a_stop_idle: assert property ($rose(i_sda) && i_scl && $past(i_scl) |-> ##[1:5] !o_busy)
      else $error("stop did not return the port to idle");
   a_timeout_idle: assert property (idle_ff > P_TIMEOUT_CYCLES + 8 |-> !o_busy)
      else $error("stalled bus did not abandon the transaction");
   a_pull_hold: assert property ($fell(o_sda_oe_n) |-> !o_sda_oe_n [*6])
      else $error("data pull-low shorter than a bus clock phase");
   a_change_scl_low: assert property ($changed(o_sda_oe_n) && o_busy |-> !$past(i_scl))
      else $error("data line changed while bus clock high");
   a_idle_released: assert property (!o_busy && $past(!o_busy) |-> o_sda_oe_n)
      else $error("data line held low while idle");
   a_wr_strobe: assert property (o_reg_wr.strobe |-> o_busy && o_reg_wr.addr == $past(o_reg_addr)
      ##1 !o_reg_wr.strobe)
      else $error("register write strobe wrong");
   a_rd_spacing: assert property (o_reg_rd_pulse |-> o_busy ##1 !o_reg_rd_pulse [*8])
      else $error("read load pulse wrong");
   a_ptr_kept: assert property ($changed(o_reg_addr) |-> o_busy)
      else $error("pointer changed outside a transaction");
   c_write: cover property (o_reg_wr.strobe);
   c_read: cover property (o_reg_rd_pulse);
   c_timeout: cover property ($fell(o_busy) && idle_ff > 100);
endmodule : i2crp_chk
bind i2crp_slave i2crp_chk #(.P_TIMEOUT_CYCLES(P_TIMEOUT_CYCLES)) chk_u (
   .i_clock(i_clock), .i_rst_n(i_rst_n), .i_scl(i_scl), .i_sda(i_sda),
   .i_address_select_pin(i_address_select_pin), .i_reg_rdata(i_reg_rdata), .o_sda_o(o_sda_o),
   .o_sda_oe_n(o_sda_oe_n), .o_reg_addr(o_reg_addr), .o_reg_wr(o_reg_wr),
   .o_reg_rd_pulse(o_reg_rd_pulse), .o_busy(o_busy));
`default_nettype wire

/* File: verification/i2crp_mst_mdl.sv */
/* Behavioural bus master that clocks the two-wire port at a 320 ns bit period.
   Assumes a pull-up on the data line; the model only pulls it low or releases it. */
`timescale 1ns/1ps
`default_nettype none
module i2crp_mst_mdl (
   output logic      o_scl,
   output logic      o_sda_low,
   input  wire logic i_sda
);
   localparam time Q = 80ns;
   initial begin
      o_scl = 1'b1;
      o_sda_low = 1'b0;
   end
   // Every step is a whole number of system clocks, so bus edges keep the bench's small offset.
   // A fixed odd delay here would drift with each repeated start and land on a clock edge.
   task automatic start_cond();
      #Q o_sda_low = 1'b0;
      #Q o_scl = 1'b1;
      #(2*Q) o_sda_low = 1'b1;
      #(2*Q) o_scl = 1'b0;
      #Q;
   endtask : start_cond
   task automatic stop_cond();
      o_sda_low = 1'b1;
      #Q o_scl = 1'b1;
      #(2*Q) o_sda_low = 1'b0;
      #(2*Q);
   endtask : stop_cond
   task automatic bit_io(input logic b, output logic r);
      o_sda_low = ~b;
      #Q o_scl = 1'b1;
      #Q r = i_sda;
      #Q o_scl = 1'b0;
      #Q;
   endtask : bit_io
   // The ninth bit carries the master's acknowledge on reads and is released on writes.
   task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
      for (int i = 8; i >= 0; i--) begin
         bit_io(tx[i], rx[i]);
      end
   endtask : xfer
endmodule : i2crp_mst_mdl
`default_nettype wire

/* File: verification/i2c_slave_register_port_tb_top.sv */
/* Self-checking bench: master model on the bus, register file modelled here.
   Assumes the design answers read data combinationally from the bench array. */
`timescale 1ns/1ps
`default_nettype none
module i2c_slave_register_port_tb_top;
   typedef struct {logic sel; logic [6:0] adr; logic [7:0] ptr; logic [7:0] dat; logic ack;} i2crp_row_t;
   localparam int unsigned TMO = 2000;
   logic                 clock = 1'b0;
   logic                 rst_n = 1'b0;
   logic                 asel = 1'b0;
   logic                 scl, m_low, sda, sda_o, oe_n, rdp, busy, ak;
   logic [4:0]           ra;
   logic [7:0]           d;
   logic [7:0]           mem [32];
   i2crp_pkg::i2crp_wr_t wr;
   int                   bad_count, cmp_count, wr_cnt, cyc, n;
   i2crp_row_t rows [4] = '{'{1'b0, 7'h48, 8'h03, 8'hA5, 1'b1}, '{1'b1, 7'h49, 8'h05, 8'h3C, 1'b1},
                            '{1'b0, 7'h49, 8'h07, 8'h11, 1'b0}, '{1'b1, 7'h48, 8'h08, 8'h22, 1'b0}};
   assign sda = ~m_low & (oe_n | sda_o);
   always #20 clock = ~clock;
   i2crp_slave #(.P_TIMEOUT_CYCLES(TMO)) dut_u (.i_clock(clock), .i_rst_n(rst_n), .i_scl(scl), .i_sda(sda),
      .i_address_select_pin(asel), .i_reg_rdata(mem[ra]), .o_sda_o(sda_o), .o_sda_oe_n(oe_n),
      .o_reg_addr(ra), .o_reg_wr(wr), .o_reg_rd_pulse(rdp), .o_busy(busy));
   i2crp_mst_mdl mst_u (.o_scl(scl), .o_sda_low(m_low), .i_sda(sda));
   always @(posedge clock) begin
      cyc++;
      if (wr.strobe === 1'b1) begin
         mem[wr.addr] <= wr.data;
         wr_cnt++;
      end
      if (cyc == 12000) begin
         bad_count++;
         complete_run();
      end
   end
   task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk_byte
   task automatic chk_bit(input string nm, input logic e, input logic g);
      chk_byte(nm, {7'h0, e}, {7'h0, g});
   endtask : chk_bit
   task automatic send(input logic [7:0] b, output logic a);
      logic [8:0] rx;
      mst_u.xfer({b, 1'b1}, rx);
      a = ~rx[0];
   endtask : send
   task automatic recv(input logic nak, output logic [7:0] b);
      logic [8:0] rx;
      mst_u.xfer({8'hFF, nak}, rx);
      b = rx[8:1];
   endtask : recv
   task automatic stop_wait();
      mst_u.stop_cond();
      repeat (6) @(posedge clock);
      #1;
   endtask : stop_wait
   task automatic complete_run();
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : complete_run
   initial begin
      for (int i = 0; i < 32; i++) mem[i] = 8'(i) ^ 8'h5A;
      repeat (2) @(posedge clock);
      #1 rst_n = 1'b1;
      repeat (8) @(posedge clock);
      #1;
      foreach (rows[i]) begin
         asel = rows[i].sel;
         n = wr_cnt;
         mst_u.start_cond();
         send({rows[i].adr, 1'b0}, ak);
         chk_bit("addr ack", rows[i].ack, ak);
         send(rows[i].ptr, ak);
         chk_bit("ptr ack", rows[i].ack, ak);
         send(rows[i].dat, ak);
         chk_bit("data ack", rows[i].ack, ak);
         stop_wait();
         chk_byte("writes", rows[i].ack ? 8'h01 : 8'h00, 8'(wr_cnt - n));
         mst_u.start_cond();
         send({rows[i].adr, 1'b1}, ak);
         recv(1'b1, d);
         stop_wait();
         chk_byte("read", rows[i].ack ? rows[i].dat : 8'hFF, d);
         $display("row %0d done", i);
      end
      asel = 1'b0;
      mst_u.start_cond();
      send(8'h90, ak);
      send(8'h9E, ak);
      for (int i = 0; i < 3; i++) send(8'hD0 + 8'(i), ak);
      mst_u.start_cond();
      send(8'h90, ak);
      send(8'h9E, ak);
      mst_u.start_cond();
      send(8'h91, ak);
      for (int i = 0; i < 3; i++) begin
         recv(i == 2, d);
         chk_byte("burst", 8'hD0 + 8'(i), d);
      end
      stop_wait();
      chk_byte("pointer", 8'h01, {3'h0, ra});
      $display("burst done");
      n = wr_cnt;
      mst_u.start_cond();
      send(8'h90, ak);
      send(8'h04, ak);
      for (int i = 0; i < 4; i++) mst_u.bit_io(1'b0, ak);
      stop_wait();
      chk_byte("abort writes", 8'h00, 8'(wr_cnt - n));
      chk_bit("abort busy", 1'b0, busy);
      mst_u.start_cond();
      send(8'h90, ak);
      for (int i = 0; i < 3; i++) mst_u.bit_io(1'b1, ak);
      mst_u.start_cond();
      send(8'h91, ak);
      chk_bit("restart ack", 1'b1, ak);
      recv(1'b1, d);
      stop_wait();
      chk_byte("restart read", 8'h5E, d);
      $display("abort done");
      mst_u.start_cond();
      send(8'h90, ak);
      repeat (TMO + 100) @(posedge clock);
      #1;
      chk_bit("timeout busy", 1'b0, busy);
      chk_bit("timeout release", 1'b1, oe_n);
      stop_wait();
      $display("timeout done");
      rst_n = 1'b0;
      #1;
      chk_bit("reset release", 1'b1, oe_n);
      chk_byte("reset pointer", 8'h00, {3'h0, ra});
      chk_bit("reset busy", 1'b0, busy);
      chk_bit("reset strobe", 1'b0, wr.strobe);
      $display("reset done");
      complete_run();
   end
endmodule : i2c_slave_register_port_tb_top
`default_nettype wire
